/* File: design/pdmc_ctrl.sv */
// Power-down, wake-up and reset sequencing controller
//
// What this block does
// - Idle opcode executed by the core enters idle mode.
// - In idle only interrupt logic and timers keep their clock.
// - Watchdog reset from idle defaults control registers, keeps data, slowest clock.
// - Enabled interrupt ends idle; clock selection kept, interrupt serviced.
// - With all interrupts masked only reset or a supply drop ends idle.
// - Stop wakes on external lines only; idle wakes on any unmasked interrupt.
// - Supply drop seen by detector in normal or idle mode enters backup, oscillator stopped.
// - Backup ignores interrupts and watchdog; left only by reset on supply rise.
// - Stop halts oscillator, core and peripherals, keeps register file.
// - Any exit from stop clears the unlock key register.
// - Stop ends on power-on reset, enabled external line, or port zero falling edge.
// - Power-on reset from stop defaults registers, loses data, fetches vector.
// - External wake from stop resets when option bit is 0.
// - External wake without reset keeps control registers other than the unlock key, and clock.
// - Port zero falling edge ends stop even with interrupt disabled.
// - Abnormal port zero state blocks stop entry.
// - Port two bit zero has no recovery; disabled edge keeps stop.
// - Reset held sixteen clocks after supply valid; defaults loaded on entry and held throughout.
// - Reset disables interrupts, enables watchdog, ports input, loads vector.
// - Pattern in timer control upper nibble disables watchdog reset.
// - Detector off in stop, so supply drop there does not enter backup.
// - Clock defaults to divide by sixteen after reset.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module pdmc_ctrl (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire pdmc_pkg::pdmc_bus_req_t bus_req,
	output logic [pdmc_pkg::DATA_W-1:0] bus_rdata,
	input  wire pdmc_pkg::pdmc_instr_t instr,
	input  wire logic [7:0]            int_req,
	input  wire logic                  bt_overflow,
	input  wire logic [7:0]            port_zero,
	input  wire logic                  port_two_bit_zero,
	input  wire logic                  low_voltage_detector,
	input  wire logic                  internal_power_on_reset,
	input  wire logic                  option_reset_ctrl,
	output pdmc_pkg::pdmc_gate_t       gate,
	output logic                       sys_reset,
	output logic                       port_force_input,
	output logic                       pullup_off,
	output logic                       int_disable,
	output logic                       fetch_enable,
	output logic                       pc_load,
	output logic [15:0]                reset_vector,
	output logic                       idle_release,
	output logic                       stop_wake_irq,
	output logic [1:0]                 clock_select_control,
	output logic                       data_invalid
);

	typedef struct packed {
		pdmc_pkg::pdmc_state_t st;
		logic [3:0]            div_cnt;
		logic [11:0]           stab_cnt;
		logic [7:0]            stop_unlock_key_reg;
		logic [7:0]            clk_sel_reg;
		logic [7:0]            interrupt_mask_reg;
		logic [7:0]            bt_ctrl_reg;
		logic [7:0]            ext_en_reg;
		logic [7:0]            rdata;
		logic [7:0]            p0_prev;
		logic                  p2_prev;
		logic                  data_invalid;
		logic [1:0]            cause;
		logic                  pc_load;
		logic                  idle_rel;
		logic                  wake_irq;
	} pdmc_ctrl_st_t;

	pdmc_ctrl_st_t state_reg;
	pdmc_ctrl_st_t state_next;

	logic [pdmc_pkg::SYNC_W-1:0] pins_s;
	logic [7:0]                  p0_s;
	logic                        p2_s;
	logic                        lvd_s;
	logic                        por_s;
	logic                        opt_s;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	pdmc_sync #(
		.W (pdmc_pkg::SYNC_W)
	) u_sync (
		.core_clk (core_clk),
		.srst     (srst),
		.async_in ({port_zero, port_two_bit_zero, low_voltage_detector,
			internal_power_on_reset, option_reset_ctrl}),
		.sync_out (pins_s)
	);

	assign p0_s  = pins_s[11:4];
	assign p2_s  = pins_s[3];
	assign lvd_s = pins_s[2];
	assign por_s = pins_s[1];
	assign opt_s = pins_s[0];

	////////////////////////////////////////////////////////////////////////////
	// Event decode

	logic [7:0]  p0_fall;
	logic [5:0]  ext_fall;
	logic        ext_hit;
	logic        int_hit;
	logic        wdt_en;
	logic        wdt_rst;
	logic        abnormal;
	logic        key_ok;
	logic        tick;
	logic [1:0]  div_sel;
	logic [3:0]  div_last;
	logic [1:0]  stab_sel;
	logic [11:0] wake_lim;
	logic        in_stop;
	logic        in_backup;

	assign in_stop   = (state_reg.st == pdmc_pkg::ST_STOP);
	assign in_backup = (state_reg.st == pdmc_pkg::ST_BACKUP);

	// Falling edges on the synchronised port pins
	assign p0_fall  = state_reg.p0_prev & ~p0_s;
	assign ext_fall = {state_reg.p2_prev & ~p2_s, p0_fall[4:0]};

	// External line counts only if enabled and unmasked
	assign ext_hit = |(ext_fall & state_reg.ext_en_reg[5:0]
		& state_reg.interrupt_mask_reg[5:0]);
	assign int_hit = |(int_req & state_reg.interrupt_mask_reg) | ext_hit;

	// Watchdog reset unless disabled, in backup or in stop
	assign wdt_en  = state_reg.bt_ctrl_reg[pdmc_pkg::WDT_NIB_LSB +: 4]
		!= pdmc_pkg::WDT_OFF_PAT;
	assign wdt_rst = bt_overflow & wdt_en & ~in_backup & ~in_stop;

	// A low port zero pin gives stop no falling edge to wake on, so refuse entry
	assign abnormal = ~&p0_s;
	assign key_ok   = state_reg.stop_unlock_key_reg == pdmc_pkg::STOP_KEY;

	////////////////////////////////////////////////////////////////////////////
	// System clock divider

	assign div_sel  = state_reg.clk_sel_reg[pdmc_pkg::CLK_SEL_LSB +: 2];
	assign stab_sel = state_reg.bt_ctrl_reg[pdmc_pkg::BT_STAB_LSB +: 2];

	// Division from the selection bit pair
	always_comb
	begin
		case (div_sel)
			pdmc_pkg::DIV16: div_last = pdmc_pkg::LAST16;
			pdmc_pkg::DIV8:  div_last = pdmc_pkg::LAST8;
			pdmc_pkg::DIV2:  div_last = pdmc_pkg::LAST2;
			default:         div_last = pdmc_pkg::LAST1;
		endcase
	end

	assign tick = (state_reg.div_cnt >= div_last);

	// Wake stabilization grows fourfold per step of the timer setting
	assign wake_lim = pdmc_pkg::RESET_STAB_CYCLES << {stab_sel, 1'b0};

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb
	begin
		state_next          = state_reg;
		state_next.pc_load  = 1'b0;
		state_next.idle_rel = 1'b0;
		state_next.wake_irq = 1'b0;
		state_next.rdata    = 8'h00;
		state_next.p0_prev  = p0_s;
		state_next.p2_prev  = p2_s;
		state_next.div_cnt  = tick ? 4'h0 : state_reg.div_cnt + 4'h1;

		// Register writes from the core
		if (bus_req.wr && state_reg.st != pdmc_pkg::ST_RESET)
		begin
			case (bus_req.addr)
				pdmc_pkg::OFS_STOP_KEY: state_next.stop_unlock_key_reg = bus_req.wdata;
				pdmc_pkg::OFS_CLK_SEL:  state_next.clk_sel_reg = bus_req.wdata;
				pdmc_pkg::OFS_INT_MASK: state_next.interrupt_mask_reg = bus_req.wdata;
				pdmc_pkg::OFS_BT_CTRL:  state_next.bt_ctrl_reg = bus_req.wdata;
				pdmc_pkg::OFS_EXT_EN:   state_next.ext_en_reg = bus_req.wdata;
				default:                state_next.rdata = 8'h00;
			endcase
		end

		// Register reads, answered one cycle later
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				pdmc_pkg::OFS_STOP_KEY: state_next.rdata = state_reg.stop_unlock_key_reg;
				pdmc_pkg::OFS_CLK_SEL:  state_next.rdata = state_reg.clk_sel_reg;
				pdmc_pkg::OFS_INT_MASK: state_next.rdata = state_reg.interrupt_mask_reg;
				pdmc_pkg::OFS_BT_CTRL:  state_next.rdata = state_reg.bt_ctrl_reg;
				pdmc_pkg::OFS_EXT_EN:   state_next.rdata = state_reg.ext_en_reg;
				pdmc_pkg::OFS_STATUS:   state_next.rdata = {state_reg.data_invalid,
					state_reg.cause, 2'b00, state_reg.st};
				default:                state_next.rdata = 8'h00;
			endcase
		end

		// Mode sequencing
		case (state_reg.st)
			pdmc_pkg::ST_RESET:
			begin
				// Count only once the supply is valid
				if (por_s)
					state_next.stab_cnt = 12'h000;
				else if (state_reg.stab_cnt == pdmc_pkg::RESET_STAB_CYCLES - 12'h001)
				begin
					state_next.st      = pdmc_pkg::ST_RUN;
					state_next.pc_load = 1'b1;
				end
				else
					state_next.stab_cnt = state_reg.stab_cnt + 12'h001;
			end
			pdmc_pkg::ST_RUN:
			begin
				if (lvd_s)
					state_next.st = pdmc_pkg::ST_BACKUP;
				else if (instr.valid && instr.opcode == pdmc_pkg::OPC_IDLE)
					state_next.st = pdmc_pkg::ST_IDLE;
				else if (instr.valid && instr.opcode == pdmc_pkg::OPC_STOP
					&& key_ok && !abnormal)
					state_next.st = pdmc_pkg::ST_STOP;
				// Stop without key or with a low port pin falls through
			end
			pdmc_pkg::ST_IDLE:
			begin
				if (lvd_s)
					state_next.st = pdmc_pkg::ST_BACKUP;
				else if (int_hit)
				begin
					state_next.st       = pdmc_pkg::ST_RUN;
					state_next.idle_rel = 1'b1;
				end
			end
			pdmc_pkg::ST_STOP:
			begin
				// Detector ignored here; port two bit zero needs its enable
				if (ext_hit || (|p0_fall))
				begin
					state_next.stop_unlock_key_reg = pdmc_pkg::RST_STOP_KEY;
					state_next.stab_cnt = 12'h000;
					if (!opt_s)
					begin
						state_next.st    = pdmc_pkg::ST_RESET;
						state_next.cause = pdmc_pkg::CAUSE_WAKE;
					end
					else
						state_next.st = pdmc_pkg::ST_WAKE;
				end
			end
			pdmc_pkg::ST_WAKE:
			begin
				// Registers and clock bits untouched on this path
				if (state_reg.stab_cnt >= wake_lim - 12'h001)
				begin
					state_next.st       = pdmc_pkg::ST_RUN;
					state_next.wake_irq = 1'b1;
				end
				else
					state_next.stab_cnt = state_reg.stab_cnt + 12'h001;
			end
			pdmc_pkg::ST_BACKUP:
			begin
				// Interrupts have no path out of backup
				if (!lvd_s)
				begin
					state_next.st       = pdmc_pkg::ST_RESET;
					state_next.stab_cnt = 12'h000;
					state_next.cause    = pdmc_pkg::CAUSE_LVD;
				end
			end
			default:
				state_next.st = pdmc_pkg::ST_RESET;
		endcase

		// Watchdog reset keeps data contents
		if (wdt_rst)
		begin
			state_next.st       = pdmc_pkg::ST_RESET;
			state_next.stab_cnt = 12'h000;
			state_next.cause    = pdmc_pkg::CAUSE_WDT;
		end

		// Power-on reset wins from every mode and loses data
		if (por_s)
		begin
			state_next.st           = pdmc_pkg::ST_RESET;
			state_next.stab_cnt     = 12'h000;
			state_next.cause        = pdmc_pkg::CAUSE_POR;
			state_next.data_invalid = 1'b1;
		end

		// Any reset loads control defaults
		if (state_next.st == pdmc_pkg::ST_RESET)
		begin
			state_next.stop_unlock_key_reg = pdmc_pkg::RST_STOP_KEY;
			state_next.clk_sel_reg         = pdmc_pkg::RST_CLK_SEL;
			state_next.interrupt_mask_reg  = pdmc_pkg::RST_INT_MASK;
			state_next.bt_ctrl_reg         = pdmc_pkg::RST_BT_CTRL;
			state_next.ext_en_reg          = pdmc_pkg::RST_EXT_EN;
		end

		// Clean boot from a non power-on reset keeps data valid
		if (state_reg.st == pdmc_pkg::ST_RESET && state_next.st == pdmc_pkg::ST_RUN
			&& state_reg.cause != pdmc_pkg::CAUSE_POR)
			state_next.data_invalid = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state_reg                     <= '0;
			state_reg.st                  <= pdmc_pkg::ST_RESET;
			state_reg.stop_unlock_key_reg <= pdmc_pkg::RST_STOP_KEY;
			state_reg.clk_sel_reg         <= pdmc_pkg::RST_CLK_SEL;
			state_reg.interrupt_mask_reg  <= pdmc_pkg::RST_INT_MASK;
			state_reg.bt_ctrl_reg         <= pdmc_pkg::RST_BT_CTRL;
			state_reg.ext_en_reg          <= pdmc_pkg::RST_EXT_EN;
			state_reg.p0_prev             <= 8'hFF;
			state_reg.p2_prev             <= 1'b1;
			state_reg.data_invalid        <= 1'b1;
			state_reg.cause               <= pdmc_pkg::CAUSE_POR;
		end
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Core and ordinary peripherals run only in normal mode
	assign gate.cpu_clk_en    = (state_reg.st == pdmc_pkg::ST_RUN) & tick;
	assign gate.periph_clk_en = (state_reg.st == pdmc_pkg::ST_RUN) & tick;

	// Interrupt logic and timers also run in idle
	assign gate.keep_clk_en = ((state_reg.st == pdmc_pkg::ST_RUN)
		| (state_reg.st == pdmc_pkg::ST_IDLE)) & tick;

	// Oscillator halted in stop and backup
	assign gate.osc_run    = ~in_stop & ~in_backup;
	assign gate.lvd_enable = ~in_stop;

	// Reset sequence outputs
	assign sys_reset        = (state_reg.st == pdmc_pkg::ST_RESET);
	assign port_force_input = sys_reset;
	assign pullup_off       = sys_reset;
	assign int_disable      = sys_reset | in_backup;
	assign fetch_enable     = (state_reg.st == pdmc_pkg::ST_RUN);
	assign pc_load          = state_reg.pc_load;
	assign reset_vector     = pdmc_pkg::RESET_VECTOR;

	// Wake notifications to the core
	assign idle_release  = state_reg.idle_rel;
	assign stop_wake_irq = state_reg.wake_irq;

	// Register-driven status
	assign clock_select_control = div_sel;
	assign data_invalid         = state_reg.data_invalid;
	assign bus_rdata            = state_reg.rdata;

endmodule

/* File: design/pdmc_pkg.sv */
// Shared constants, types and state layout for the power-down controller
package pdmc_pkg;

	// Register bus widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// Instruction decode
	localparam logic [7:0] OPC_IDLE = 8'h6F;
	localparam logic [7:0] OPC_STOP = 8'h7F; // Plain default, core may differ

	// Stop unlock key and watchdog disable pattern
	localparam logic [7:0] STOP_KEY    = 8'hA5;
	localparam logic [3:0] WDT_OFF_PAT = 4'h5;

	// Program reset address
	localparam logic [15:0] RESET_VECTOR = 16'h0100;

	// Oscillator stabilization counts
	localparam logic [11:0] RESET_STAB_CYCLES = 12'h010;

	// Register offsets
	localparam logic [7:0] OFS_STOP_KEY = 8'h00;
	localparam logic [7:0] OFS_CLK_SEL  = 8'h01;
	localparam logic [7:0] OFS_INT_MASK = 8'h02;
	localparam logic [7:0] OFS_BT_CTRL  = 8'h03;
	localparam logic [7:0] OFS_EXT_EN   = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h05;

	// Reset values
	localparam logic [7:0] RST_STOP_KEY = 8'h00;
	localparam logic [7:0] RST_CLK_SEL  = 8'h00;
	localparam logic [7:0] RST_INT_MASK = 8'h00;
	localparam logic [7:0] RST_BT_CTRL  = 8'h00;
	localparam logic [7:0] RST_EXT_EN   = 8'h00;

	// Field positions
	localparam int unsigned CLK_SEL_LSB = 3;
	localparam int unsigned BT_STAB_LSB = 2;
	localparam int unsigned WDT_NIB_LSB = 4;

	// Clock division codes
	localparam logic [1:0] DIV16 = 2'h0;
	localparam logic [1:0] DIV8  = 2'h1;
	localparam logic [1:0] DIV2  = 2'h2;
	localparam logic [3:0] LAST16 = 4'hF;
	localparam logic [3:0] LAST8  = 4'h7;
	localparam logic [3:0] LAST2  = 4'h1;
	localparam logic [3:0] LAST1  = 4'h0;

	// Reset cause codes
	localparam logic [1:0] CAUSE_POR  = 2'h0;
	localparam logic [1:0] CAUSE_WDT  = 2'h1;
	localparam logic [1:0] CAUSE_LVD  = 2'h2;
	localparam logic [1:0] CAUSE_WAKE = 2'h3;

	// Synchronised pin count
	localparam int unsigned SYNC_W = 12;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_RUN,
		ST_IDLE,
		ST_STOP,
		ST_WAKE,
		ST_BACKUP
	} pdmc_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} pdmc_bus_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] opcode;
	} pdmc_instr_t;

	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic keep_clk_en;
		logic osc_run;
		logic lvd_enable;
	} pdmc_gate_t;

endpackage

/* File: design/pdmc_sync.sv */
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/100ps
module pdmc_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pdmc_sync_st_t;

	pdmc_sync_st_t state_reg;
	pdmc_sync_st_t state_next;

	// First stage feeds only the second
	always_comb
	begin
		state_next        = state_reg;
		state_next.meta   = async_in;
		state_next.stable = state_reg.meta;
	end

	// Pins idle high after reset
	always_ff @(posedge core_clk)
	begin
		if (srst)
			state_reg <= '1;
		else
			state_reg <= state_next;
	end

	assign sync_out = state_reg.stable;

endmodule

/* File: test/pdmc_ctrl_checker.sv */
// Controller port assertions
`timescale 1ns/100ps
module pdmc_ctrl_checker (
	input wire logic                 core_clk,
	input wire logic                 srst,
	input wire logic                 low_voltage_detector,
	input wire logic                 internal_power_on_reset,
	input wire pdmc_pkg::pdmc_gate_t gate,
	input wire logic                 sys_reset,
	input wire logic                 port_force_input,
	input wire logic                 pullup_off,
	input wire logic                 int_disable,
	input wire logic                 fetch_enable,
	input wire logic                 pc_load,
	input wire logic                 idle_release,
	input wire logic                 stop_wake_irq,
	input wire logic [1:0]           clock_select_control
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	//////////////////////////////////////////////////////////////////////////
	// Reset pulse length, saturating
	logic [4:0] hold_cnt_reg;
	always_ff @(posedge core_clk)
	begin
		if (srst || !sys_reset)
			hold_cnt_reg <= 5'h00;
		else if (hold_cnt_reg != 5'h1F)
			hold_cnt_reg <= hold_cnt_reg + 5'h01;
	end

	//////////////////////////////////////////////////////////////////////////
	// Supply drop outlasting the synchroniser
	sequence s_supply_drop;
		fetch_enable && low_voltage_detector && !internal_power_on_reset
		##1 (low_voltage_detector && !internal_power_on_reset) [*3];
	endsequence
	sequence s_in_backup;
		!gate.osc_run && gate.lvd_enable;
	endsequence

	property p_pins;
		sys_reset |-> port_force_input && pullup_off && int_disable && !fetch_enable;
	endproperty
	a_pins: assert property (p_pins)
		else $error("Reset side outputs wrong");
	property p_hold;
		$fell(sys_reset) |-> hold_cnt_reg >= 5'h10;
	endproperty
	a_hold: assert property (p_hold)
		else $error("Reset released too early");
	property p_pc_load;
		pc_load == $fell(sys_reset);
	endproperty
	a_pc_load: assert property (p_pc_load)
		else $error("Vector load not at reset exit");
	property p_clk_gate;
		(gate.cpu_clk_en || gate.periph_clk_en) |-> fetch_enable && gate.osc_run;
	endproperty
	a_clk_gate: assert property (p_clk_gate)
		else $error("Core clock outside run");
	property p_lvd_off;
		!gate.lvd_enable |-> !gate.osc_run && !fetch_enable && !sys_reset;
	endproperty
	a_lvd_off: assert property (p_lvd_off)
		else $error("Detector off outside stop");
	property p_clk_default;
		$fell(sys_reset) |-> clock_select_control == pdmc_pkg::DIV16;
	endproperty
	a_clk_default: assert property (p_clk_default)
		else $error("Clock not slowest after reset");
	property p_backup_entry;
		s_supply_drop |-> !gate.osc_run && gate.lvd_enable && int_disable;
	endproperty
	a_backup_entry: assert property (p_backup_entry)
		else $error("Supply drop not in backup");
	property p_backup_quiet;
		s_in_backup |-> !idle_release && !stop_wake_irq && !sys_reset;
	endproperty
	a_backup_quiet: assert property (p_backup_quiet)
		else $error("Backup left or woken");
	property p_idle_release;
		idle_release |-> $stable(clock_select_control) && !sys_reset;
	endproperty
	a_idle_release: assert property (p_idle_release)
		else $error("Idle release changed clock");
	property p_wake_irq;
		stop_wake_irq |-> $stable(clock_select_control) && !sys_reset && gate.osc_run;
	endproperty
	a_wake_irq: assert property (p_wake_irq)
		else $error("Stop wake changed clock");
endmodule

bind pdmc_ctrl pdmc_ctrl_checker pdmc_ctrl_checker_i (
	.core_clk(core_clk), .srst(srst), .low_voltage_detector(low_voltage_detector),
	.internal_power_on_reset(internal_power_on_reset), .gate(gate), .sys_reset(sys_reset),
	.port_force_input(port_force_input), .pullup_off(pullup_off), .int_disable(int_disable),
	.fetch_enable(fetch_enable), .pc_load(pc_load), .idle_release(idle_release),
	.stop_wake_irq(stop_wake_irq), .clock_select_control(clock_select_control)
);

/* File: test/pdmc_core_model.sv */
// Core model: register cycles, instructions
`timescale 1ns/100ps
module pdmc_core_model (
	input  wire logic               core_clk,
	input  wire logic [7:0]         bus_rdata,
	output pdmc_pkg::pdmc_bus_req_t bus_req,
	output pdmc_pkg::pdmc_instr_t   instr
);
	initial
	begin
		bus_req = '0;
		instr = '0;
	end

	//////////////////////////////////////////////////////////////////////////
	// Idle bus shows inverted values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
		#1;
		d = bus_rdata;
	endtask
	task automatic exec(input logic [7:0] op);
		@(posedge core_clk);
		instr <= '{valid: 1'b1, opcode: op};
		@(posedge core_clk);
		instr <= '{valid: 1'b0, opcode: ~op};
	endtask
	// Stabilization, key, stop opcode
	task automatic stop(input logic [1:0] stab);
		wr(pdmc_pkg::OFS_BT_CTRL, {4'h0, stab, 2'b00});
		wr(pdmc_pkg::OFS_STOP_KEY, pdmc_pkg::STOP_KEY);
		exec(pdmc_pkg::OPC_STOP);
	endtask
endmodule

/* File: test/pdmc_ctrl_test.sv */
// Controller bench
`timescale 1ns/100ps
module pdmc_ctrl_test;
	logic                    core_clk;
	logic                    srst;
	pdmc_pkg::pdmc_bus_req_t bus_req;
	logic [7:0]              bus_rdata;
	pdmc_pkg::pdmc_instr_t   instr;
	logic [7:0]              int_req;
	logic                    bt_overflow;
	logic [7:0]              port_zero;
	logic                    port_two_bit_zero;
	logic                    supply_low;
	logic                    supply_bad;
	logic                    option_reset;
	pdmc_pkg::pdmc_gate_t    gate;
	logic                    sys_reset;
	logic                    fetch_enable;
	logic                    idle_release;
	logic                    stop_wake_irq;
	logic [1:0]              clock_select_control;
	logic [7:0]              rdata;
	logic [15:0]             rvec;
	logic [1:0]              sel;
	logic [7:0]              irq;
	int                      n_errors;
	int                      n_compared;
	int                      n;
	int                      b;
	int unsigned             r;
	wire  [3:0]              watch = {stop_wake_irq, idle_release, sys_reset, fetch_enable};

	pdmc_ctrl pdmc_ctrl_i (.core_clk(core_clk), .srst(srst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .instr(instr), .int_req(int_req), .bt_overflow(bt_overflow),
		.port_zero(port_zero), .port_two_bit_zero(port_two_bit_zero),
		.low_voltage_detector(supply_low), .internal_power_on_reset(supply_bad),
		.option_reset_ctrl(option_reset), .gate(gate), .sys_reset(sys_reset),
		.port_force_input(), .pullup_off(), .int_disable(), .fetch_enable(fetch_enable),
		.pc_load(), .reset_vector(rvec), .idle_release(idle_release),
		.stop_wake_irq(stop_wake_irq), .clock_select_control(clock_select_control),
		.data_invalid());
	pdmc_core_model pdmc_core_model_i (.core_clk(core_clk), .bus_rdata(bus_rdata),
		.bus_req(bus_req), .instr(instr));

	// Free-running core clock
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	//////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [7:0] st_exp(logic inv, logic [1:0] cause, logic [2:0] st);
		return {inv, cause, 2'b00, st};
	endfunction
	task automatic summarize();
		if (n_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
		pdmc_core_model_i.rd(a, rdata);
		chk(rdata, exp, what);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	// Bounded wait
	task automatic wait_hi(input int idx, input int lim);
		n = 0;
		while (watch[idx] !== 1'b1)
		begin
			cyc(1);
			n++;
			if (n > lim)
			begin
				n_errors++;
				$display("ERROR %0t wait ran out", $time);
				summarize();
			end
		end
	endtask
	task automatic pulse_bt();
		@(posedge core_clk);
		bt_overflow <= 1'b1;
		@(posedge core_clk);
		bt_overflow <= 1'b0;
	endtask

	//////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		srst = 1'b1;
		int_req = 8'h00;
		bt_overflow = 1'b0;
		port_zero = 8'hFF;
		port_two_bit_zero = 1'b1;
		supply_low = 1'b0;
		supply_bad = 1'b0;
		option_reset = 1'b1;
		n_errors = 0;
		n_compared = 0;
		r = $urandom(28);
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		wait_hi(0, 40);
		chk_reg(pdmc_pkg::OFS_STATUS, st_exp(1, 0, pdmc_pkg::ST_RUN), "boot");
		chk(rvec[15:8], 8'h01, "vector");
		chk(rvec[7:0], 8'h00, "vector");
		for (int a = 0; a < 5; a++)
			chk_reg(8'(a), 8'h00, "default");
		chk_reg(8'h07, 8'h00, "unmapped");
		// All divider codes, then random
		for (int s = 0; s < 5; s++)
		begin
			sel = (s < 4) ? 2'(s) : 2'($urandom_range(3, 1));
			pdmc_core_model_i.wr(pdmc_pkg::OFS_CLK_SEL, 8'(sel) << pdmc_pkg::CLK_SEL_LSB);
			cyc(1);
			chk(8'(clock_select_control), 8'(sel), "clksel");
		end
		// Idle: masked, then unmasked
		irq = 8'h01 << $urandom_range(7, 0);
		pdmc_core_model_i.exec(pdmc_pkg::OPC_IDLE);
		int_req <= irq;
		cyc(8);
		chk(8'(fetch_enable), 8'h00, "idle masked");
		chk_reg(pdmc_pkg::OFS_STATUS, st_exp(1, 0, pdmc_pkg::ST_IDLE), "idle st");
		pdmc_core_model_i.wr(pdmc_pkg::OFS_INT_MASK, irq);
		wait_hi(2, 10);
		cyc(1);
		chk(8'(fetch_enable), 8'h01, "idle wake");
		chk(8'(clock_select_control), 8'(sel), "idle clk");
		int_req <= 8'h00;
		// Stop refused: no key, then pin low
		pdmc_core_model_i.exec(pdmc_pkg::OPC_STOP);
		cyc(3);
		chk(8'(gate.osc_run), 8'h01, "no key");
		b = $urandom_range(7, 0);
		port_zero <= ~(8'h01 << b);
		pdmc_core_model_i.stop(2'b00);
		cyc(3);
		chk(8'(fetch_enable), 8'h01, "abnormal");
		port_zero <= 8'hFF;
		cyc(3);
		// Stop held: disabled line five, supply drop
		pdmc_core_model_i.stop(2'b00);
		cyc(2);
		chk(8'({gate.osc_run, gate.lvd_enable, fetch_enable}), 8'h00, "stop");
		port_two_bit_zero <= 1'b0;
		supply_low <= 1'b1;
		cyc(8);
		chk_reg(pdmc_pkg::OFS_STATUS, st_exp(1, 0, pdmc_pkg::ST_STOP), "held");
		supply_low <= 1'b0;
		port_two_bit_zero <= 1'b1;
		cyc(3);
		// Port zero wake, no-reset option
		port_zero <= ~(8'h01 << b);
		wait_hi(3, 200);
		chk(8'(n >= 16), 8'h01, "stab len");
		chk_reg(pdmc_pkg::OFS_STATUS, st_exp(1, 0, pdmc_pkg::ST_RUN), "no rst");
		chk_reg(pdmc_pkg::OFS_STOP_KEY, 8'h00, "key clr");
		chk(8'(clock_select_control), 8'(sel), "stop clk");
		port_zero <= 8'hFF;
		// Line five wake, reset option
		pdmc_core_model_i.wr(pdmc_pkg::OFS_EXT_EN, 8'h20);
		pdmc_core_model_i.wr(pdmc_pkg::OFS_INT_MASK, 8'h20);
		option_reset <= 1'b0;
		pdmc_core_model_i.stop(2'b01);
		cyc(4);
		port_two_bit_zero <= 1'b0;
		wait_hi(1, 20);
		wait_hi(0, 40);
		chk_reg(pdmc_pkg::OFS_STATUS, st_exp(0, 3, pdmc_pkg::ST_RUN), "ext rst");
		chk_reg(pdmc_pkg::OFS_STOP_KEY, 8'h00, "key clr2");
		port_two_bit_zero <= 1'b1;
		// Power-on reset out of stop
		pdmc_core_model_i.stop(2'b00);
		cyc(3);
		supply_bad <= 1'b1;
		cyc(5);
		supply_bad <= 1'b0;
		wait_hi(0, 60);
		chk_reg(pdmc_pkg::OFS_STATUS, st_exp(1, 0, pdmc_pkg::ST_RUN), "por");
		// Backup ignores interrupts, watchdog
		supply_low <= 1'b1;
		cyc(6);
		int_req <= 8'hFF;
		pulse_bt();
		cyc(4);
		chk(8'({gate.osc_run, sys_reset}), 8'h00, "backup");
		supply_low <= 1'b0;
		int_req <= 8'h00;
		wait_hi(1, 10);
		wait_hi(0, 40);
		chk_reg(pdmc_pkg::OFS_STATUS, st_exp(0, 2, pdmc_pkg::ST_RUN), "lvd rst");
		// Watchdog from idle, then off
		pdmc_core_model_i.wr(pdmc_pkg::OFS_CLK_SEL, 8'h18);
		pdmc_core_model_i.exec(pdmc_pkg::OPC_IDLE);
		pulse_bt();
		wait_hi(1, 10);
		wait_hi(0, 40);
		chk_reg(pdmc_pkg::OFS_STATUS, st_exp(0, 1, pdmc_pkg::ST_RUN), "wdt");
		chk(8'(clock_select_control), 8'h00, "idle rst clk");
		pdmc_core_model_i.wr(pdmc_pkg::OFS_BT_CTRL, {pdmc_pkg::WDT_OFF_PAT, 4'h0});
		pulse_bt();
		cyc(5);
		chk(8'({sys_reset, fetch_enable}), 8'h01, "wdt off");
		summarize();
	end
endmodule
